/* File: common/sio_pkg.sv */
// Purpose: shared constants, states and helpers of the serial port
// Assumes: 8-bit register port, 16x oversampled asynchronous bit timing
// Notes:   register offsets are byte addresses on the register port
package sio_pkg;
   // -----------------------------------------------------------------
   // register addresses
   // -----------------------------------------------------------------
   localparam logic [15:0] ASIM_ADDR = 16'hFF70;
   localparam logic [15:0] STAT_ADDR = 16'hFF71;
   localparam logic [15:0] CSIM_ADDR = 16'hFF72;
   localparam logic [15:0] BRGC_ADDR = 16'hFF73;
   localparam logic [15:0] DATA_ADDR = 16'hFF74;
   // -----------------------------------------------------------------
   // field positions
   // -----------------------------------------------------------------
   localparam int ASIM_TXE  = 7;
   localparam int ASIM_RXE  = 6;
   localparam int ASIM_PS1  = 5;
   localparam int ASIM_PS0  = 4;
   localparam int ASIM_CL   = 3;
   localparam int ASIM_SL   = 2;
   localparam int CSIM_EN   = 7;
   localparam int CSIM_DAP  = 3;
   localparam int CSIM_DIR  = 2;
   localparam int CSIM_CSCK = 1;
   localparam int CSIM_CKP  = 0;
   localparam int ST_PE     = 2;
   localparam int ST_FE     = 1;
   localparam int ST_OVE    = 0;
   localparam int BRGC_EXT  = 7;
   // -----------------------------------------------------------------
   // reset values, encodings and counts
   // -----------------------------------------------------------------
   localparam logic [7:0] ASIM_RST = 8'h00;
   localparam logic [7:0] CSIM_RST = 8'h00;
   localparam logic [7:0] BRGC_RST = 8'h00;
   localparam logic [7:0] TXS_RST  = 8'hFF;
   localparam logic [1:0] PAR_NONE = 2'h0;
   localparam logic [1:0] PAR_ZERO = 2'h1;
   localparam logic [1:0] PAR_ODD  = 2'h2;
   localparam logic [1:0] PAR_EVEN = 2'h3;
   localparam logic [3:0] PH_LAST  = 4'hF;
   localparam logic [3:0] PH_MID   = 4'h7;
   localparam logic [3:0] CSI_BITS = 4'h8;
   localparam logic [4:0] CSI_EDGE = 5'h10;

   typedef enum logic [5:0] {
      TX_IDLE  = 6'h01,
      TX_START = 6'h02,
      TX_DATA  = 6'h04,
      TX_PAR   = 6'h08,
      TX_STOP  = 6'h10,
      TX_CSI   = 6'h20
   } tx_state_e;

   typedef enum logic [4:0] {
      RX_IDLE  = 5'h01,
      RX_START = 5'h02,
      RX_DATA  = 5'h04,
      RX_PAR   = 5'h08,
      RX_STOP  = 5'h10
   } rx_state_e;

   // index of the last data bit for 7- or 8-bit characters
   function automatic logic [3:0] last_bit(input logic cl);
      last_bit = cl ? 4'h7 : 4'h6;
   endfunction

   // parity bit for the running xor of the data bits
   function automatic logic par_bit(input logic [1:0] ps, input logic x);
      par_bit = (ps == PAR_EVEN) ? x : (ps == PAR_ODD) ? ~x : 1'b0;
   endfunction
endpackage

/* File: common/sio_baud_if.sv */
// Purpose: link between the port core and its bit-rate divider
// Assumes: single clock domain
// Notes:   tick is a one-cycle enable
`timescale 1ns/1ps
interface sio_baud_if;
   logic       run;
   logic       ext_sel;
   logic       ext_lvl;
   logic [6:0] div;
   logic       tick;
   modport gen  (input run, ext_sel, ext_lvl, div, output tick);
   modport user (output run, ext_sel, ext_lvl, div, input tick);
endinterface

/* File: verilog/sio_sync3.sv */
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: inputs asynchronous to ref_clk_i
// Notes:   output moves only when stages two and three agree
`timescale 1ns/1ps
module sio_sync3 #(
   parameter int           W   = 4,
   parameter logic [W-1:0] RST = '1
)(
   input  wire logic         ref_clk_i,
   input  wire logic         rst_n_i,
   input  wire logic [W-1:0] d_i,
   output logic [W-1:0]      q_o
);
   logic [W-1:0] s1_r, s2_r, s3_r, q_r, q_nxt;

   // hold the old value while the two late stages disagree
   always_comb
   begin
      q_nxt = (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & q_r);
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         s1_r <= RST;
         s2_r <= RST;
         s3_r <= RST;
         q_r  <= RST;
      end
      else
      begin
         s1_r <= d_i;
         s2_r <= s1_r;
         s3_r <= s2_r;
         q_r  <= q_nxt;
      end
   end

   assign q_o = q_r;
endmodule

/* File: verilog/sio_baud.sv */
// Purpose: bit-rate divider for both serial modes
// Assumes: external clock level already synchronised
// Notes:   tick fires every div+1 source events
`timescale 1ns/1ps
module sio_baud
   import sio_pkg::*;
(
   input  wire logic ref_clk_i,
   input  wire logic rst_n_i,
   sio_baud_if.gen   b
);
   logic [6:0] cnt_r, cnt_nxt;
   logic       prev_r, prev_nxt, tick_r, tick_nxt, ev;

   // count system clocks or rising edges of the external clock
   always_comb
   begin
      ev       = b.ext_sel ? (b.ext_lvl & ~prev_r) : 1'b1;
      prev_nxt = b.ext_lvl;
      cnt_nxt  = cnt_r;
      tick_nxt = 1'b0;
      if (!b.run)
         cnt_nxt = 7'h00;
      else if (ev)
      begin
         if (cnt_r >= b.div)
         begin
            cnt_nxt  = 7'h00;
            tick_nxt = 1'b1;
         end
         else
            cnt_nxt = cnt_r + 7'h01;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         cnt_r  <= 7'h00;
         prev_r <= 1'b1; // matches the synchroniser reset level, no false edge
         tick_r <= 1'b0;
      end
      else
      begin
         cnt_r  <= cnt_nxt;
         prev_r <= prev_nxt;
         tick_r <= tick_nxt;
      end
   end

   assign b.tick = tick_r;

   a_tick_stopped: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      !b.run |=> !b.tick) else $error("divider ticks while stopped");
endmodule

/* File: verilog/dual_mode_serial_port.sv */
// Purpose: serial port with stop, asynchronous and three-wire modes
// Assumes: 8-bit register port; pins asynchronous to ref_clk_i
// Notes:   read data appears one cycle after rd_i
`timescale 1ns/1ps
module dual_mode_serial_port
   import sio_pkg::*;
(
   input  wire logic        ref_clk_i,
   input  wire logic        rst_n_i,
   input  wire logic [15:0] addr_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   input  wire logic [7:0]  wdata_i,
   output logic [7:0]       rdata_o,
   input  wire logic        receive_data_pin_i,
   input  wire logic        serial_in_pin_i,
   input  wire logic        serial_clock_pin_i,
   input  wire logic        async_ext_clock_pin_i,
   output logic             serial_out_pin_o,
   output logic             serial_clock_pin_o,
   output logic             serial_clock_pin_oe_o,
   output logic             tx_done_o,
   output logic             rx_done_o
);
   // ----------------------------------------------------------------
   // pins, mode decode and divider
   // ----------------------------------------------------------------
   logic [3:0] pins_s;
   logic [7:0] asim_r, asim_nxt, csim_r, csim_nxt, brgc_r, brgc_nxt;
   logic       csi_mode, txen, rxen, stop_mode, tick, cl, rxd;
   logic [1:0] ps;
   sio_baud_if bif ();

   sio_sync3 #(.W(4), .RST(4'hF)) u_sync (
      .ref_clk_i (ref_clk_i),
      .rst_n_i   (rst_n_i),
      .d_i       ({async_ext_clock_pin_i, serial_clock_pin_i,
                   serial_in_pin_i, receive_data_pin_i}),
      .q_o       (pins_s)
   );

   sio_baud u_baud (
      .ref_clk_i (ref_clk_i),
      .rst_n_i   (rst_n_i),
      .b         (bif.gen)
   );

   // one mode at a time; three-wire enable overrides the async enables
   assign csi_mode    = csim_r[CSIM_EN];
   assign txen        = asim_r[ASIM_TXE] & ~csi_mode;
   assign rxen        = asim_r[ASIM_RXE] & ~csi_mode;
   assign stop_mode   = ~csi_mode & ~txen & ~rxen;
   assign cl          = asim_r[ASIM_CL];
   assign ps          = asim_r[ASIM_PS1:ASIM_PS0];
   assign rxd         = pins_s[0];
   assign bif.run     = txen | rxen | (csi_mode & csim_r[CSIM_CSCK]);
   assign bif.ext_sel = brgc_r[BRGC_EXT];
   assign bif.ext_lvl = pins_s[3];
   assign bif.div     = brgc_r[6:0];
   assign tick        = bif.tick;

   // ----------------------------------------------------------------
   // transmit and three-wire shifter
   // ----------------------------------------------------------------
   tx_state_e  tx_st_r, tx_st_nxt;
   logic [7:0] tx_sh_r, tx_sh_nxt;
   logic [3:0] tx_cnt_r, tx_cnt_nxt, tx_ph_r, tx_ph_nxt;
   logic [4:0] tgl_r, tgl_nxt;
   logic       tx_par_r, tx_par_nxt, so_r, so_nxt, sck_r, sck_nxt, oe_r, oe_nxt;
   logic       lvl_r, tx_done_r, tx_done_nxt, csi_done_r, csi_done_nxt;
   logic       wr_data, lvl, rise, fall, out_e, smp_e, bit_end, dir;

   assign wr_data = wr_i & (addr_i == DATA_ADDR);
   assign dir     = csim_r[CSIM_DIR];
   assign lvl     = csim_r[CSIM_CSCK] ? sck_r : pins_s[2];
   assign rise    = lvl & ~lvl_r;
   assign fall    = ~lvl & lvl_r;
   assign out_e   = csim_r[CSIM_DAP] ? rise : fall;
   assign smp_e   = csim_r[CSIM_DAP] ? fall : rise;
   assign bit_end = tick & (tx_ph_r == PH_LAST);

   // framing and three-wire shifting
   always_comb
   begin
      tx_st_nxt    = tx_st_r;
      tx_sh_nxt    = tx_sh_r;
      tx_cnt_nxt   = tx_cnt_r;
      tx_ph_nxt    = tick ? tx_ph_r + 4'h1 : tx_ph_r;
      tx_par_nxt   = tx_par_r;
      so_nxt       = so_r;
      sck_nxt      = sck_r;
      tgl_nxt      = tgl_r;
      oe_nxt       = csi_mode & csim_r[CSIM_CSCK];
      tx_done_nxt  = 1'b0;
      csi_done_nxt = 1'b0;
      unique case (tx_st_r)
         TX_IDLE:
         begin
            sck_nxt   = ~csim_r[CSIM_CKP];
            tx_ph_nxt = 4'h0;
            if (!csi_mode)
               so_nxt = 1'b1;
            if (wr_data)
            begin
               tx_sh_nxt  = wdata_i;
               tx_cnt_nxt = 4'h0;
               tx_par_nxt = 1'b0;
               tgl_nxt    = 5'h00;
               if (csi_mode)
               begin
                  tx_st_nxt = TX_CSI;
                  so_nxt    = dir ? wdata_i[0] : wdata_i[7];
               end
               else if (txen)
                  tx_st_nxt = TX_START;
            end
         end
         TX_START:
         begin
            so_nxt = 1'b0;
            if (bit_end)
               tx_st_nxt = TX_DATA;
         end
         TX_DATA:
         begin
            so_nxt = tx_sh_r[0];
            if (bit_end)
            begin
               tx_sh_nxt  = {1'b1, tx_sh_r[7:1]};
               tx_par_nxt = tx_par_r ^ tx_sh_r[0];
               tx_cnt_nxt = tx_cnt_r + 4'h1;
               if (tx_cnt_r == last_bit(cl))
               begin
                  tx_cnt_nxt = 4'h0;
                  tx_st_nxt  = (ps == PAR_NONE) ? TX_STOP : TX_PAR;
               end
            end
         end
         TX_PAR:
         begin
            so_nxt = par_bit(ps, tx_par_r);
            if (bit_end)
               tx_st_nxt = TX_STOP;
         end
         TX_STOP:
         begin
            so_nxt = 1'b1;
            if (bit_end)
            begin
               tx_cnt_nxt = tx_cnt_r + 4'h1;
               if (tx_cnt_r[0] == asim_r[ASIM_SL])
               begin
                  tx_st_nxt   = TX_IDLE;
                  tx_done_nxt = 1'b1;
               end
            end
         end
         TX_CSI:
         begin
            if (csim_r[CSIM_CSCK] && tick && tgl_r != CSI_EDGE)
            begin
               sck_nxt = ~sck_r;
               tgl_nxt = tgl_r + 5'h01;
            end
            if (smp_e && tx_cnt_r != CSI_BITS)
            begin
               tx_sh_nxt  = dir ? {pins_s[1], tx_sh_r[7:1]} : {tx_sh_r[6:0], pins_s[1]};
               tx_cnt_nxt = tx_cnt_r + 4'h1;
            end
            if (out_e && tx_cnt_r != 4'h0 && tx_cnt_r != CSI_BITS)
               so_nxt = dir ? tx_sh_r[0] : tx_sh_r[7];
            if (tx_cnt_r == CSI_BITS && (!csim_r[CSIM_CSCK] || tgl_r == CSI_EDGE))
            begin
               tx_st_nxt    = TX_IDLE;
               tx_done_nxt  = 1'b1;
               csi_done_nxt = 1'b1;
            end
         end
         default:
            tx_st_nxt = TX_IDLE;
      endcase
      // a mode change abandons the transfer in flight
      if ((tx_st_r == TX_CSI && !csi_mode) ||
          (tx_st_r != TX_CSI && tx_st_r != TX_IDLE && !txen))
         tx_st_nxt = TX_IDLE;
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         tx_st_r    <= TX_IDLE;
         tx_sh_r    <= TXS_RST;
         tx_cnt_r   <= 4'h0;
         tx_ph_r    <= 4'h0;
         tx_par_r   <= 1'b0;
         so_r       <= 1'b1;
         sck_r      <= 1'b1;
         tgl_r      <= 5'h00;
         oe_r       <= 1'b0;
         lvl_r      <= 1'b1;
         tx_done_r  <= 1'b0;
         csi_done_r <= 1'b0;
      end
      else
      begin
         tx_st_r    <= tx_st_nxt;
         tx_sh_r    <= tx_sh_nxt;
         tx_cnt_r   <= tx_cnt_nxt;
         tx_ph_r    <= tx_ph_nxt;
         tx_par_r   <= tx_par_nxt;
         so_r       <= so_nxt;
         sck_r      <= sck_nxt;
         tgl_r      <= tgl_nxt;
         oe_r       <= oe_nxt;
         lvl_r      <= lvl;
         tx_done_r  <= tx_done_nxt;
         csi_done_r <= csi_done_nxt;
      end
   end

   // ----------------------------------------------------------------
   // asynchronous receiver
   // ----------------------------------------------------------------
   rx_state_e  rx_st_r, rx_st_nxt;
   logic [7:0] rx_sh_r, rx_sh_nxt;
   logic [3:0] rx_cnt_r, rx_cnt_nxt, rx_ph_r, rx_ph_nxt;
   logic       rx_par_r, rx_par_nxt, perr_r, perr_nxt, rx_prev_r;
   logic       rx_ev_r, rx_ev_nxt, rx_pe_r, rx_pe_nxt, rx_fe_r, rx_fe_nxt, smp;

   assign smp = tick & (rx_ph_r == PH_LAST);

   // start detect, mid-bit sampling and error checks
   always_comb
   begin
      rx_st_nxt  = rx_st_r;
      rx_sh_nxt  = rx_sh_r;
      rx_cnt_nxt = rx_cnt_r;
      rx_ph_nxt  = tick ? rx_ph_r + 4'h1 : rx_ph_r;
      rx_par_nxt = rx_par_r;
      perr_nxt   = perr_r;
      rx_ev_nxt  = 1'b0;
      rx_pe_nxt  = 1'b0;
      rx_fe_nxt  = 1'b0;
      unique case (rx_st_r)
         RX_IDLE:
         begin
            rx_ph_nxt = 4'h0;
            if (rxen && rx_prev_r && !rxd)
               rx_st_nxt = RX_START;
         end
         RX_START:
         begin
            if (tick && rx_ph_r == PH_MID)
            begin
               rx_ph_nxt  = 4'h0;
               rx_cnt_nxt = 4'h0;
               rx_par_nxt = 1'b0;
               perr_nxt   = 1'b0;
               rx_st_nxt  = rxd ? RX_IDLE : RX_DATA;
            end
         end
         RX_DATA:
         begin
            if (smp)
            begin
               rx_sh_nxt  = {rxd, rx_sh_r[7:1]};
               rx_par_nxt = rx_par_r ^ rxd;
               rx_cnt_nxt = rx_cnt_r + 4'h1;
               if (rx_cnt_r == last_bit(cl))
                  rx_st_nxt = (ps == PAR_NONE) ? RX_STOP : RX_PAR;
            end
         end
         RX_PAR:
         begin
            if (smp)
            begin
               perr_nxt  = (ps[1] == 1'b1) && (rxd != par_bit(ps, rx_par_r));
               rx_st_nxt = RX_STOP;
            end
         end
         RX_STOP:
         begin
            if (smp)
            begin
               rx_ev_nxt = 1'b1;
               rx_pe_nxt = perr_r;
               rx_fe_nxt = ~rxd;
               rx_st_nxt = RX_IDLE;
            end
         end
         default:
            rx_st_nxt = RX_IDLE;
      endcase
      if (!rxen)
         rx_st_nxt = RX_IDLE;
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rx_st_r   <= RX_IDLE;
         rx_sh_r   <= 8'h00;
         rx_cnt_r  <= 4'h0;
         rx_ph_r   <= 4'h0;
         rx_par_r  <= 1'b0;
         perr_r    <= 1'b0;
         rx_prev_r <= 1'b1;
         rx_ev_r   <= 1'b0;
         rx_pe_r   <= 1'b0;
         rx_fe_r   <= 1'b0;
      end
      else
      begin
         rx_st_r   <= rx_st_nxt;
         rx_sh_r   <= rx_sh_nxt;
         rx_cnt_r  <= rx_cnt_nxt;
         rx_ph_r   <= rx_ph_nxt;
         rx_par_r  <= rx_par_nxt;
         perr_r    <= perr_nxt;
         rx_prev_r <= rxd;
         rx_ev_r   <= rx_ev_nxt;
         rx_pe_r   <= rx_pe_nxt;
         rx_fe_r   <= rx_fe_nxt;
      end
   end

   // ----------------------------------------------------------------
   // register file and receive buffer
   // ----------------------------------------------------------------
   logic [7:0] stat_r, stat_nxt, rbuf_r, rbuf_nxt, rdata_r, rdata_nxt;
   logic       full_r, full_nxt, rx_done_r, rx_done_nxt, rd_data, rx_load;

   assign rd_data = rd_i & (addr_i == DATA_ADDR);
   assign rx_load = rx_ev_r | csi_done_r;

   // writes, sticky status with set over clear, registered reads
   always_comb
   begin
      asim_nxt    = (wr_i && addr_i == ASIM_ADDR) ? wdata_i : asim_r;
      csim_nxt    = (wr_i && addr_i == CSIM_ADDR) ? wdata_i : csim_r;
      brgc_nxt    = (wr_i && addr_i == BRGC_ADDR) ? wdata_i : brgc_r;
      stat_nxt    = (rd_i && addr_i == STAT_ADDR) ? 8'h00 : stat_r;
      stat_nxt[ST_PE]  = stat_nxt[ST_PE] | (rx_ev_r & rx_pe_r);
      stat_nxt[ST_FE]  = stat_nxt[ST_FE] | (rx_ev_r & rx_fe_r);
      stat_nxt[ST_OVE] = stat_nxt[ST_OVE] | (rx_load & full_r & ~rd_data);
      full_nxt    = (full_r & ~rd_data) | rx_load;
      rbuf_nxt    = rbuf_r;
      if (rx_ev_r)
         rbuf_nxt = cl ? rx_sh_r : {1'b0, rx_sh_r[7:1]};
      else if (csi_done_r)
         rbuf_nxt = tx_sh_r;
      rx_done_nxt = rx_load;
      rdata_nxt   = rdata_r;
      if (rd_i)
      begin
         unique case (addr_i)
            ASIM_ADDR: rdata_nxt = asim_r;
            STAT_ADDR: rdata_nxt = stat_r;
            CSIM_ADDR: rdata_nxt = csim_r;
            BRGC_ADDR: rdata_nxt = brgc_r;
            DATA_ADDR: rdata_nxt = rbuf_r;
            default:   rdata_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         asim_r    <= ASIM_RST;
         csim_r    <= CSIM_RST;
         brgc_r    <= BRGC_RST;
         stat_r    <= 8'h00;
         rbuf_r    <= 8'h00;
         full_r    <= 1'b0;
         rx_done_r <= 1'b0;
         rdata_r   <= 8'h00;
      end
      else
      begin
         asim_r    <= asim_nxt;
         csim_r    <= csim_nxt;
         brgc_r    <= brgc_nxt;
         stat_r    <= stat_nxt;
         rbuf_r    <= rbuf_nxt;
         full_r    <= full_nxt;
         rx_done_r <= rx_done_nxt;
         rdata_r   <= rdata_nxt;
      end
   end

   assign rdata_o               = rdata_r;
   assign serial_out_pin_o      = so_r;
   assign serial_clock_pin_o    = sck_r;
   assign serial_clock_pin_oe_o = oe_r;
   assign tx_done_o             = tx_done_r;
   assign rx_done_o             = rx_done_r;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);

   a_stop_quiet: assert property (stop_mode && tx_st_r == TX_IDLE && rx_st_r == RX_IDLE
      |=> tx_st_r == TX_IDLE && rx_st_r == RX_IDLE) else $error("activity in stop");
   a_write_starts: assert property (wr_data && tx_st_r == TX_IDLE && txen
      |=> tx_st_r == TX_START ##1 !so_r) else $error("no start bit");
   a_seven_bits: assert property (tx_st_r == TX_DATA && !cl
      |-> tx_cnt_r <= 4'h6) else $error("eighth bit sent");
   a_tx_reset: assert property ($rose(rst_n_i)
      |-> tx_sh_r == TXS_RST) else $error("bad reset value");
   a_shared_read: assert property (rd_data
      |=> rdata_r == $past(rbuf_r)) else $error("bad data read");
   a_write_keeps: assert property (wr_data && !rx_load
      |=> $stable(rbuf_r)) else $error("write hit buffer");
   a_rx_msb_zero: assert property (rx_ev_r && !cl
      |=> !rbuf_r[7]) else $error("msb not zero");
   a_parity_flag: assert property (rx_ev_r && rx_pe_r
      |=> stat_r[ST_PE]) else $error("parity flag lost");
   a_csi_count: assert property (tx_st_r == TX_CSI
      |-> tx_cnt_r <= CSI_BITS) else $error("too many bits");
   a_sck_idle: assert property (tx_st_r == TX_IDLE
      |=> sck_r == !$past(csim_r[CSIM_CKP])) else $error("bad idle clock");
   a_start_seen: assert property (rx_st_r == RX_IDLE && rxen && rx_prev_r && !rxd
      |=> rx_st_r == RX_START) else $error("start missed");

   c_uart_tx: cover property (tx_st_r == TX_STOP ##1 tx_done_r);
   c_rx_parity: cover property (rx_ev_r && ps == PAR_EVEN);
   c_csi_done: cover property (csi_done_r);
   c_overrun: cover property (rx_load && full_r);
endmodule

/* File: verif/uart_peer.sv */
// Purpose: far-end asynchronous peer that sends and captures frames
// Assumes: divisor 0, so one bit lasts 16 clocks of 10 ns
// Notes:   line idles high; capture keeps the last 8 data slots
`timescale 1ns/1ps
module uart_peer (
   input  wire logic  line_i,
   output logic       line_o,
   output logic [7:0] got_o
);
   localparam int BT = 160;
   initial line_o = 1'b1;
   // start, data lsb first, optional parity, one stop
   task automatic send(input logic [7:0] d, input logic pen, input logic p);
      line_o <= 1'b0;
      #BT;
      for (int i = 0; i < 8; i++)
      begin
         line_o <= d[i];
         #BT;
      end
      if (pen)
      begin
         line_o <= p;
         #BT;
      end
      line_o <= 1'b1;
      #BT;
   endtask
   // sample each data slot at its middle
   always @(negedge line_i)
   begin
      #(BT / 2);
      for (int i = 0; i < 8; i++)
      begin
         #BT;
         got_o[i] = line_i;
      end
      #BT;
   end
endmodule

/* File: verif/tb_top.sv */
// Purpose: register-level tests of the serial port
// Assumes: divisor 0 for asynchronous traffic
// Notes:   three-wire data out loops back to data in
`timescale 1ns/1ps
module tb_top
   import sio_pkg::*;
;
   logic        clk, rst_n, wr, rd, rxd, sout, sclk, sclk_oe, txd, rxdn, ext_sck, aclk, arun;
   logic [15:0] addr;
   logic [7:0]  wdata, rdata, got;
   int          fail_count, comparisons, cyc;
   uart_peer peer (.line_i(sout), .line_o(rxd), .got_o(got));
   dual_mode_serial_port dut (.ref_clk_i(clk), .rst_n_i(rst_n), .addr_i(addr), .wr_i(wr),
      .rd_i(rd), .wdata_i(wdata), .rdata_o(rdata), .receive_data_pin_i(rxd),
      .serial_in_pin_i(sout), .serial_clock_pin_i(ext_sck), .async_ext_clock_pin_i(aclk),
      .serial_out_pin_o(sout), .serial_clock_pin_o(sclk), .serial_clock_pin_oe_o(sclk_oe),
      .tx_done_o(txd), .rx_done_o(rxdn));
   initial clk = 1'b0;
   always #5 clk = ~clk;
   // external bit-rate clock, levels long enough for the pin filter
   always #40 aclk = arun ? ~aclk : aclk;
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      comparisons++;
      if (g !== e)
      begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata, e);
   endtask
   task automatic wait_done(input logic rx);
      int n;
      n = 0;
      while (((rx ? rxdn : txd) !== 1'b1) && n < 4000)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      chk({7'h00, n < 4000}, 8'h01);
   endtask
   // one frame from the peer while waiting for the receive pulse
   task automatic rx_frame(input logic [7:0] d, input logic pen, input logic p);
      fork
         peer.send(d, pen, p);
         wait_done(1'b1);
      join
   endtask
   task automatic test_done();
      if (fail_count == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // cycle ceiling against hangs
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         fail_count++;
         test_done();
      end
   end
   initial
   begin
      rst_n = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 16'h0000;
      wdata = 8'h00;
      ext_sck = 1'b1;
      aclk = 1'b0;
      arun = 1'b0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      // reset values, unmapped read, stop mode
      rd_chk(ASIM_ADDR, ASIM_RST);
      rd_chk(16'hFF7F, 8'h00);
      wr_reg(DATA_ADDR, 8'h00);
      repeat (200) @(posedge clk);
      chk({6'h00, sout, txd}, 8'h02);
      // asynchronous transmit, 8 and 7 bits
      wr_reg(ASIM_ADDR, 8'hC8);
      wr_reg(DATA_ADDR, 8'hA5);
      wait_done(1'b0);
      chk(got, 8'hA5);
      wr_reg(ASIM_ADDR, 8'hC0);
      wr_reg(DATA_ADDR, 8'h05);
      wait_done(1'b0);
      chk(got, 8'h85);
      // asynchronous receive, buffer and shared address
      rx_frame(8'hBC, 1'b0, 1'b0);
      rd_chk(DATA_ADDR, 8'h3C);
      wr_reg(ASIM_ADDR, 8'hC8);
      rx_frame(8'hC3, 1'b0, 1'b0);
      rd_chk(DATA_ADDR, 8'hC3);
      wr_reg(DATA_ADDR, 8'h5A);
      wait_done(1'b0);
      rd_chk(DATA_ADDR, 8'hC3);
      chk(got, 8'h5A);
      // parity error, then overrun on an unread buffer
      wr_reg(ASIM_ADDR, 8'hF8);
      rx_frame(8'hC3, 1'b1, 1'b1);
      rd_chk(STAT_ADDR, 8'h04);
      rd_chk(STAT_ADDR, 8'h00);
      rx_frame(8'h11, 1'b1, 1'b0);
      rd_chk(STAT_ADDR, 8'h01);
      rd_chk(DATA_ADDR, 8'h11);
      // bit timing from the external clock pin: no edges, no progress
      wr_reg(BRGC_ADDR, 8'h80);
      wr_reg(DATA_ADDR, 8'hA5);
      repeat (300) @(posedge clk);
      chk({7'h00, sout}, 8'h00);
      arun <= 1'b1;
      wait_done(1'b0);
      arun <= 1'b0;
      // three-wire, internal clock, MSB first, idle high
      wr_reg(ASIM_ADDR, 8'h00);
      wr_reg(BRGC_ADDR, 8'h07);
      wr_reg(CSIM_ADDR, 8'h82);
      @(posedge clk);
      #1;
      chk({6'h00, sclk, sclk_oe}, 8'h03);
      wr_reg(DATA_ADDR, 8'h96);
      wait_done(1'b0);
      rd_chk(DATA_ADDR, 8'h96);
      // three-wire, LSB first, idle low, other data phase
      wr_reg(CSIM_ADDR, 8'h8F);
      @(posedge clk);
      #1;
      chk({6'h00, sclk, sclk_oe}, 8'h01);
      wr_reg(DATA_ADDR, 8'h4B);
      wait_done(1'b0);
      rd_chk(DATA_ADDR, 8'h4B);
      // three-wire, clock from the pin, not driven by the port
      wr_reg(CSIM_ADDR, 8'h80);
      @(posedge clk);
      #1;
      chk({6'h00, sclk, sclk_oe}, 8'h02);
      wr_reg(DATA_ADDR, 8'h69);
      fork
         repeat (16)
         begin
            repeat (8) @(posedge clk);
            ext_sck <= ~ext_sck;
         end
         wait_done(1'b0);
      join
      rd_chk(DATA_ADDR, 8'h69);
      test_done();
   end
endmodule
